// file: inc/scg_consts.svh
// offsets, field positions, reset values and counts of the converter
// configuration registers; definitions only
`ifndef SCG_CONSTS_SVH
`define SCG_CONSTS_SVH

`define SCG_ADDR_RATE_UPPER  8'h1A
`define SCG_ADDR_RATE_LOWER  8'h1B
`define SCG_ADDR_IDLE_TIME   8'h1C
`define SCG_ADDR_SYNC_RESET  8'h1D
`define SCG_ADDR_PIN_SETUP   8'h1E

`define SCG_RST_RATE_UPPER   8'h00
`define SCG_RST_RATE_LOWER   8'h00
`define SCG_RST_IDLE_TIME    8'h00
`define SCG_RST_SYNC_RESET   8'h80
`define SCG_RST_PIN_SETUP    8'h00

`define SCG_RATE_UPPER_MASK  8'h1F
`define SCG_SYNC_RW_MASK     8'h4B
`define SCG_SYNC_TRIG_BIT    7
`define SCG_SYNC_POSEDGE_BIT 6
`define SCG_SYNC_PSTART_BIT  3
`define SCG_PIN_GLOBAL_BIT   7
`define SCG_PIN_OD_LSB       4
`define SCG_PIN_OD_MSB       6

`define SCG_FILT_SINC3       3'h3
`define SCG_DECIM_UNIT       32
`define SCG_KEY_ARM          2'h3
`define SCG_KEY_FIRE         2'h2
`define SCG_NUM_PINS         4
`define SCG_NUM_OD_PINS      3

`endif

// file: inc/scg_pkg.sv
// types shared by the configuration register block and its helpers
package scg_pkg;
   typedef logic [7:0] scg_byte_t;
   typedef logic [2:0] scg_filt_t;
   typedef enum logic {SCG_RUN, SCG_IDLE} scg_standby_e;
endpackage

// file: inc/scg_ctl_if.sv
// signals between the register block and its sync and reset-key helpers
// assumes all parties share clk
`timescale 1ns/100ps
interface scg_ctl_if;
   logic       sync_req;     // one-cycle request for a sync pulse
   logic       sync_posedge; // 1: drive low on rising edge
   logic       sync_out_n;
   logic       sync_done;    // pulse issued, trigger bit may return
   logic       key_wr;       // write to sync/reset register
   logic [1:0] key_bits;
   logic       soft_reset;   // one-cycle full reset request

   modport regs (output sync_req, sync_posedge, key_wr, key_bits,
                 input sync_out_n, sync_done, soft_reset);
   modport sync (input sync_req, sync_posedge, output sync_out_n, sync_done);
   modport key  (input key_wr, key_bits, output soft_reset);
endinterface

// file: design/scg_sync_pulse.sv
// one-cycle low sync pulse, launched on the rising or falling clock edge
// assumes requests arrive as single-cycle strobes on clk
`timescale 1ns/100ps
module scg_sync_pulse
   import scg_pkg::*;
(
   input  wire logic clk,
   input  wire logic resetn,
   scg_ctl_if.sync   ctl
);
   logic pos_n_r;
   logic neg_n_r;

   // rising-edge launch: low for exactly one cycle after the request
   always_ff @(posedge clk)
   begin
      if (!resetn)
         pos_n_r <= 1'b1;
      else
         pos_n_r <= ~ctl.sync_req;
   end

   // falling-edge copy, half a cycle later, for the default edge
   always_ff @(negedge clk)
   begin
      if (!resetn)
         neg_n_r <= 1'b1;
      else
         neg_n_r <= pos_n_r;
   end

   // edge select picks which flop drives the line; select is static in use
   assign ctl.sync_out_n = ctl.sync_posedge ? pos_n_r : neg_n_r;
   assign ctl.sync_done  = ~pos_n_r;
endmodule

// file: design/scg_reset_key.sv
// two-write software reset key detector on the reset bits
// assumes key_wr pulses once per host write to the sync/reset register
`timescale 1ns/100ps
module scg_reset_key
   import scg_pkg::*;
(
   input  wire logic clk,
   input  wire logic resetn,
   scg_ctl_if.key    ctl
);
   `include "scg_consts.svh"

   logic armed_r;
   logic fire_r;

   // arm on 11, fire on 10 right after; anything else disarms
   always_ff @(posedge clk)
   begin
      if (!resetn || fire_r)
      begin
         armed_r <= 1'b0;
         fire_r  <= 1'b0;
      end
      else if (ctl.key_wr)
      begin
         armed_r <= (ctl.key_bits == `SCG_KEY_ARM);
         fire_r  <= armed_r && (ctl.key_bits == `SCG_KEY_FIRE);
      end
      else
         fire_r <= 1'b0;
   end

   assign ctl.soft_reset = fire_r;
endmodule

// file: design/scg_regs.sv
// configuration registers: sinc3 decimation, periodic idle time,
// software sync and reset key, general-purpose pin setup.
// assumes a serial front end presents single-cycle register strobes on clk
// and that the filter datapath drives its strobes and selects on clk
//
// Behaviour
// - sinc3 ratio is (setting plus one) times 32
// - lower setting byte is lower-rate register
// - standby idle lasts (idle plus one) times two
// - writing trigger bit low emits sync pulse
// - trigger bit returns to one by itself
// - edge bit picks rising or falling launch
// - write 11 then 10 causes full reset
// - key detection ignores other register bits
// - pin settings change only with global enable
// - open-drain bits switch pins 2..0 drivers
// - direction bits: zero input, one output
// - sinc3 setting used only for filter 011
`timescale 1ns/100ps
module scg_regs
   import scg_pkg::*;
#(
   parameter int NPINS = 4
)
(
   input  wire logic             clk,
   input  wire logic             resetn,
   input  wire logic             reg_wr,
   input  wire logic             reg_rd,
   input  wire logic [7:0]       reg_addr,
   input  wire logic [7:0]       reg_wdata,
   output logic      [7:0]       reg_rdata,
   input  wire logic [2:0]       filter_sel,
   input  wire logic             periodic_en,
   input  wire logic             conv_done,
   input  wire logic             filt_word_stb,
   input  wire logic [NPINS-1:0] pin_level,
   output logic      [18:0]      decimation_ratio,
   output logic                  sinc3_active,
   output logic                  standby,
   output logic                  sync_out_n,
   output logic                  soft_reset,
   output logic                  pin_start_en,
   output logic      [NPINS-1:0] pin_out,
   output logic      [NPINS-1:0] pin_oe
);
   `include "scg_consts.svh"

   scg_ctl_if ctl ();

   // stored register images
   scg_byte_t    rate_upper_r;
   scg_byte_t    rate_lower_r;
   scg_byte_t    idle_time_r;
   scg_byte_t    sync_reg_r;
   scg_byte_t    pin_setup_r;
   scg_byte_t    rdata_r;
   scg_byte_t    rdata_nxt;
   // derived settings and sequencer state
   logic [12:0]  sinc_decim_setting;
   logic [18:0]  ratio_r;
   logic         sinc3_r;
   scg_standby_e stby_r;
   logic [8:0]   idle_cnt_r;
   logic [8:0]   idle_len;
   logic         soft_rst_r;
   logic         clr;
   // pin driver flops
   logic [NPINS-1:0] pin_out_r;
   logic [NPINS-1:0] pin_oe_r;

   // decoded writes
   logic wr_upper;
   logic wr_lower;
   logic wr_idle;
   logic wr_sync;
   logic wr_pins;

   // one register is hit per strobe at most
   assign wr_upper = reg_wr && (reg_addr == `SCG_ADDR_RATE_UPPER);
   assign wr_lower = reg_wr && (reg_addr == `SCG_ADDR_RATE_LOWER);
   assign wr_idle  = reg_wr && (reg_addr == `SCG_ADDR_IDLE_TIME);
   assign wr_sync  = reg_wr && (reg_addr == `SCG_ADDR_SYNC_RESET);
   assign wr_pins  = reg_wr && (reg_addr == `SCG_ADDR_PIN_SETUP);

   // a key hit resets every register here except soft_rst_r, the same as the reset pin
   assign clr = !resetn || ctl.soft_reset;

   // helpers
   // the reset pin clears them; a key reset leaves the sync helper alone, while the key helper clears itself as it fires
   scg_sync_pulse u_sync
   (
      .clk    (clk),
      .resetn (resetn),
      .ctl    (ctl.sync)
   );

   scg_reset_key u_key
   (
      .clk    (clk),
      .resetn (resetn),
      .ctl    (ctl.key)
   );

   // trigger and key bits come straight from the write data, so the helpers
   // act on a write in the same cycle it is taken
   assign ctl.sync_req     = wr_sync && !reg_wdata[`SCG_SYNC_TRIG_BIT];
   assign ctl.sync_posedge = sync_reg_r[`SCG_SYNC_POSEDGE_BIT];
   assign ctl.key_wr       = wr_sync;
   assign ctl.key_bits     = reg_wdata[1:0];

   // upper rate: only bits 4:0 store, the rest read zero
   always_ff @(posedge clk)
   begin
      if (clr)
         rate_upper_r <= `SCG_RST_RATE_UPPER;
      else if (wr_upper)
         rate_upper_r <= reg_wdata & `SCG_RATE_UPPER_MASK;
   end

   // lower rate: full byte read/write
   always_ff @(posedge clk)
   begin
      if (clr)
         rate_lower_r <= `SCG_RST_RATE_LOWER;
      else if (wr_lower)
         rate_lower_r <= reg_wdata;
   end

   // periodic idle setting
   always_ff @(posedge clk)
   begin
      if (clr)
         idle_time_r <= `SCG_RST_IDLE_TIME;
      else if (wr_idle)
         idle_time_r <= reg_wdata;
   end

   // sync/reset register: edge select, pin-start and key bits store;
   // trigger bit is written low and climbs back once the pulse is out
   always_ff @(posedge clk)
   begin
      if (clr)
         sync_reg_r <= `SCG_RST_SYNC_RESET;
      else if (wr_sync)
         sync_reg_r <= (reg_wdata & `SCG_SYNC_RW_MASK)
                       | {reg_wdata[`SCG_SYNC_TRIG_BIT], 7'h00};
      // a fresh trigger write above wins over the return of bit 7
      else if (ctl.sync_done)
         sync_reg_r[`SCG_SYNC_TRIG_BIT] <= 1'b1;
   end

   // pin setup: the rest of the byte is taken only while enable is written high
   // the enable bit itself always follows the write, so it can be dropped again
   always_ff @(posedge clk)
   begin
      if (clr)
         pin_setup_r <= `SCG_RST_PIN_SETUP;
      else if (wr_pins)
      begin
         pin_setup_r[`SCG_PIN_GLOBAL_BIT] <= reg_wdata[`SCG_PIN_GLOBAL_BIT];
         if (reg_wdata[`SCG_PIN_GLOBAL_BIT])
            pin_setup_r[6:0] <= reg_wdata[6:0];
      end
   end

   // decimation ratio, only meaningful on the sinc3 path
   // other filters see zero, so a stale setting never leaks into their path
   assign sinc_decim_setting = {rate_upper_r[4:0], rate_lower_r};

   always_ff @(posedge clk)
   begin
      if (clr)
      begin
         ratio_r <= 19'h00000;
         sinc3_r <= 1'b0;
      end
      else
      begin
         sinc3_r <= (filter_sel == `SCG_FILT_SINC3);
         // size casts keep the sum and the product at the port width
         if (filter_sel == `SCG_FILT_SINC3)
            ratio_r <= 19'({6'h00, sinc_decim_setting} + 19'h00001)
                       * 19'(`SCG_DECIM_UNIT);
         else
            ratio_r <= 19'h00000;
      end
   end

   // idle span in filter words; the host keeps this mode out of fast power
   // nine bits suffice: 255 gives 512, which wraps to zero, and the count
   // still ends on the 512th word because the compare wraps the same way
   assign idle_len = 9'({1'b0, idle_time_r} + 9'h001) << 1;

   // standby sequencer: after each conversion, wait idle_len filter words
   // dropping periodic_en parks it in run at once
   always_ff @(posedge clk)
   begin
      if (clr || !periodic_en)
      begin
         stby_r     <= SCG_RUN;
         idle_cnt_r <= 9'h000;
      end
      else
      begin
         unique case (stby_r)
            SCG_RUN:
               if (conv_done)
               begin
                  stby_r     <= SCG_IDLE;
                  idle_cnt_r <= 9'h000;
               end
            SCG_IDLE:
               if (filt_word_stb)
               begin
                  if (idle_cnt_r == idle_len - 9'h001)
                     stby_r <= SCG_RUN;
                  idle_cnt_r <= idle_cnt_r + 9'h001;
               end
         endcase
      end
   end

   // pin drivers: open drain only pulls low, push-pull follows the level
   // pin 3 has no open-drain option and drives push-pull whenever its direction bit is one
   genvar g;
   generate
      for (g = 0; g < NPINS; g++)
      begin : g_pin
         logic od;
         if (g < `SCG_NUM_OD_PINS)
            assign od = pin_setup_r[`SCG_PIN_OD_LSB + g];
         else
            assign od = 1'b0;

         always_ff @(posedge clk)
         begin
            if (clr)
            begin
               pin_out_r[g] <= 1'b0;
               pin_oe_r[g]  <= 1'b0;
            end
            else
            begin
               pin_out_r[g] <= od ? 1'b0 : pin_level[g];
               pin_oe_r[g]  <= pin_setup_r[g] && (!od || !pin_level[g]);
            end
         end
      end
   endgenerate

   // read mux; unmapped addresses read zero
   // reserved bits are stored as zero, so no read masks are needed
   always_comb
   begin
      unique case (reg_addr)
         `SCG_ADDR_RATE_UPPER: rdata_nxt = rate_upper_r;
         `SCG_ADDR_RATE_LOWER: rdata_nxt = rate_lower_r;
         `SCG_ADDR_IDLE_TIME:  rdata_nxt = idle_time_r;
         `SCG_ADDR_SYNC_RESET: rdata_nxt = sync_reg_r;
         `SCG_ADDR_PIN_SETUP:  rdata_nxt = pin_setup_r;
         default:              rdata_nxt = 8'h00;
      endcase
   end

   // read data is held until the next read
   always_ff @(posedge clk)
   begin
      if (clr)
         rdata_r <= 8'h00;
      else if (reg_rd)
         rdata_r <= rdata_nxt;
   end

   // registered copy of the reset-key helper output
   // the port pulse trails the internal clear by one cycle
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         soft_rst_r <= 1'b0;
      end
      else
      begin
         soft_rst_r <= ctl.soft_reset;
      end
   end

   // every port reads a flop, except the sync line, which picks one of two
   assign reg_rdata        = rdata_r;
   assign decimation_ratio = ratio_r;
   assign sinc3_active     = sinc3_r;
   assign standby          = (stby_r == SCG_IDLE);
   // the sync line is launched by the helper's own edge flops
   assign sync_out_n       = ctl.sync_out_n;
   assign soft_reset       = soft_rst_r;
   assign pin_start_en     = sync_reg_r[`SCG_SYNC_PSTART_BIT];
   assign pin_out          = pin_out_r;
   assign pin_oe           = pin_oe_r;
endmodule

// file: test/scg_host_model.sv
// host model: issues single-cycle register strobes to the block
// assumes strobes launch just after clk rises and one transfer at a time
`timescale 1ns/100ps
module scg_host_model
(
   input  wire logic       clk,
   output logic            reg_wr,
   output logic            reg_rd,
   output logic      [7:0] reg_addr,
   output logic      [7:0] reg_wdata,
   input  wire logic [7:0] reg_rdata
);
   // idle bus at time zero
   initial
   begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'hFF;
      reg_wdata = 8'h00;
   end

   // released lines show the inverse so stale values cannot pass
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~d;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      reg_addr <= ~a;
      @(posedge clk);
      #1 d = reg_rdata;
   endtask
endmodule

// file: test/scg_regs_asserts.sv
// checker for the configuration register block, sees top ports only
// assumes one clock domain and a registered soft reset pulse
`timescale 1ns/100ps
module scg_regs_asserts
#(
   parameter int NPINS = 4
)
(
   input wire logic             clk,
   input wire logic             resetn,
   input wire logic             reg_wr,
   input wire logic             reg_rd,
   input wire logic [7:0]       reg_addr,
   input wire logic [7:0]       reg_wdata,
   input wire logic [7:0]       reg_rdata,
   input wire logic [2:0]       filter_sel,
   input wire logic             periodic_en,
   input wire logic             conv_done,
   input wire logic             filt_word_stb,
   input wire logic [NPINS-1:0] pin_level,
   input wire logic [18:0]      decimation_ratio,
   input wire logic             sinc3_active,
   input wire logic             standby,
   input wire logic             sync_out_n,
   input wire logic             soft_reset,
   input wire logic [NPINS-1:0] pin_out,
   input wire logic [NPINS-1:0] pin_oe
);
   logic       armed_r;
   logic [7:0] pin_r;
   logic [2:0] sr_q;
   wire        k_wr = reg_wr && reg_addr == 8'h1D;
   wire        fire = k_wr && reg_wdata[1:0] == 2'h2 && armed_r;
   wire        trig = k_wr && !reg_wdata[7];
   wire  [3:0] od   = {1'b0, pin_r[6:4]};
   wire        hush = soft_reset || sr_q != 3'h0; // registers settle after a key reset

   // shadow of the key state and the pin setup
   always_ff @(posedge clk)
   begin
      if (!resetn || soft_reset)
      begin
         armed_r <= 1'b0;
         pin_r <= 8'h00;
      end
      else
      begin
         if (k_wr)
            armed_r <= reg_wdata[1:0] == 2'h3;
         if (reg_wr && reg_addr == 8'h1E)
            pin_r <= reg_wdata[7] ? reg_wdata : {1'b0, pin_r[6:0]};
      end
   end

   // quiet window after a soft reset pulse
   always_ff @(posedge clk)
      sr_q <= resetn ? {sr_q[1:0], soft_reset} : 3'h0;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn || hush);

   sequence key_fire_s;
      fire;
   endsequence
   sequence sync_low_s;
      !sync_out_n ##1 sync_out_n;
   endsequence

   key_reset_a: assert property (key_fire_s |-> ##[2:3] soft_reset)
      else $error("no soft reset after key");
   reset_only_a: assert property (disable iff (!resetn)
                                  $rose(soft_reset) |-> $past(fire, 2) || $past(fire, 3))
      else $error("soft reset without key");
   reset_pulse_a: assert property (disable iff (!resetn) soft_reset |=> !soft_reset)
      else $error("soft reset too long");
   sync_fire_a: assert property (trig |-> ##[1:3] sync_low_s)
      else $error("no sync pulse");
   sync_cause_a: assert property ($fell(sync_out_n) |-> $past(trig) || $past(trig, 2)
                                  || $past(trig, 3))
      else $error("sync pulse without trigger");
   sinc_sel_a: assert property ($past(resetn) |-> sinc3_active == ($past(filter_sel) == 3'h3))
      else $error("sinc3 select wrong");
   ratio_unit_a: assert property (decimation_ratio[4:0] == 5'h00)
      else $error("ratio not a multiple of 32");
   idle_enter_a: assert property (periodic_en && conv_done && !standby |=> standby)
      else $error("standby not entered");
   idle_hold_a: assert property (standby && !filt_word_stb |=> standby)
      else $error("standby left without filter word");
   pin_oe_a: assert property (pin_oe == $past(pin_r[3:0] & ~(od & pin_level)))
      else $error("pin enable wrong");
   pin_out_a: assert property (pin_out == $past(pin_level & ~od))
      else $error("pin output wrong");
   rd_zero_a: assert property (reg_rd && (reg_addr < 8'h1A || reg_addr > 8'h1E)
                               |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
endmodule

bind scg_regs scg_regs_asserts #(.NPINS(NPINS)) i_chk (.clk, .resetn, .reg_wr, .reg_rd,
   .reg_addr, .reg_wdata, .reg_rdata, .filter_sel, .periodic_en, .conv_done,
   .filt_word_stb, .pin_level, .decimation_ratio, .sinc3_active, .standby,
   .sync_out_n, .soft_reset, .pin_out, .pin_oe);

// file: test/sinc3_sync_gpio_config_regs_tb.sv
// self-checking bench for the configuration register block
// assumes the host model and the checker are compiled before it
`timescale 1ns/100ps
module sinc3_sync_gpio_config_regs_tb;
   logic        clk = 1'b0;
   logic        resetn = 1'b0;
   logic        periodic_en = 1'b0;
   logic        conv_done = 1'b0;
   logic        filt_word_stb = 1'b0;
   logic  [2:0] filter_sel = 3'h0;
   logic  [3:0] pin_level = 4'h0;
   logic        reg_wr, reg_rd, sinc3_active, standby, sync_out_n, soft_reset, pin_start_en;
   logic  [7:0] reg_addr, reg_wdata, reg_rdata, d, lo, pin_e;
   logic [18:0] decimation_ratio;
   logic  [3:0] pin_out, pin_oe;
   int          fail_count = 0;
   int          cmp_count = 0;
   int          n, ns, nr, nf;

   // 10 MHz clock
   initial
      forever #50 clk = ~clk;

   scg_regs #(.NPINS(4)) i_dut (.clk, .resetn, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
      .reg_rdata, .filter_sel, .periodic_en, .conv_done, .filt_word_stb, .pin_level,
      .decimation_ratio, .sinc3_active, .standby, .sync_out_n, .soft_reset,
      .pin_start_en, .pin_out, .pin_oe);
   scg_host_model i_host (.clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata);

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask

   // own read variable, so stimulus held in d survives the read
   task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] got;
      i_host.rd(a, got);
      check(got, exp);
   endtask

   // counts sync low and soft reset high over six cycles, sampling a quarter
   // period after each rising edge so either launch edge is seen exactly once;
   // nf keeps the first sample at which the sync line was low
   task automatic watch;
      ns = 0;
      nr = 0;
      nf = -1;
      for (int c = 0; c < 6; c++)
      begin
         #25;
         if (sync_out_n === 1'b0 && nf < 0)
            nf = c;
         ns += (sync_out_n === 1'b0);
         nr += (soft_reset === 1'b1);
         @(posedge clk);
      end
   endtask

   task automatic conclude;
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   function automatic logic [18:0] ratio_f(input logic [7:0] up, input logic [7:0] l,
                                            input logic [2:0] f);
      return (f == 3'h3) ? ({6'h00, up[4:0], l} + 19'h1) * 19'h20 : 19'h0;
   endfunction

   // main sequence
   initial
   begin
      void'($urandom(32'hBDE69F13));
      repeat (8) @(posedge clk);
      resetn <= 1'b1;
      rchk(8'h1A, 8'h00);
      rchk(8'h1B, 8'h00);
      rchk(8'h1C, 8'h00);
      rchk(8'h1D, 8'h80);
      rchk(8'h1E, 8'h00);
      i_host.wr(8'h1F, 8'hA5);
      rchk(8'h1F, 8'h00);
      $display("test reset values done");
      // all-ones and all-zero settings first, then random
      pin_e = 8'h00;
      for (int i = 0; i < 24; i++)
      begin
         d = (i < 2) ? {8{~i[0]}} : 8'($urandom);
         lo = (i < 2) ? d : 8'($urandom);
         @(posedge clk);
         filter_sel <= (i < 2) ? 3'h3 : 3'($urandom);
         pin_level <= 4'($urandom);
         i_host.wr(8'h1A, d);
         i_host.wr(8'h1B, lo);
         i_host.wr(8'h1C, d);
         i_host.wr(8'h1D, (d & 8'hFE) | 8'h80); // reset bits never 11 here
         i_host.wr(8'h1E, d);
         pin_e = d[7] ? d : {1'b0, pin_e[6:0]};
         rchk(8'h1A, d & 8'h1F);
         rchk(8'h1B, lo);
         rchk(8'h1C, d);
         rchk(8'h1D, (d & 8'h4A) | 8'h80);
         rchk(8'h1E, pin_e);
         check(decimation_ratio, ratio_f(d, lo, filter_sel));
         check(sinc3_active, filter_sel == 3'h3);
         check(pin_start_en, d[3]);
         check(pin_oe, pin_e[3:0] & ~({1'b0, pin_e[6:4]} & pin_level));
         check(pin_out, pin_level & ~{1'b0, pin_e[6:4]});
      end
      $display("test register access done");
      for (int e = 0; e < 2; e++)
      begin
         i_host.wr(8'h1D, {1'b1, e[0], 6'h00});
         i_host.wr(8'h1D, {1'b0, e[0], 6'h00});
         watch;
         check(ns, 1);
         check(nf, e[0] ? 0 : 1);
         rchk(8'h1D, {1'b1, e[0], 6'h00});
      end
      $display("test sync pulse done");
      i_host.wr(8'h1D, 8'h83);
      i_host.wr(8'h1D, 8'h80);
      i_host.wr(8'h1D, 8'h82);
      watch;
      check(nr, 0);
      i_host.wr(8'h1D, 8'hCB);
      i_host.wr(8'h1C, 8'h5A);
      i_host.wr(8'h1D, 8'h8A);
      watch;
      check(nr, 1);
      rchk(8'h1C, 8'h00);
      rchk(8'h1D, 8'h80);
      $display("test reset key done");
      // shortest and longest idle settings first, then random
      for (int k = 0; k < 4; k++)
      begin
         d = (k == 0) ? 8'h00 : (k == 1) ? 8'hFF : 8'($urandom_range(7));
         i_host.wr(8'h1C, d);
         periodic_en <= 1'b1;
         @(posedge clk);
         conv_done <= 1'b1;
         @(posedge clk);
         conv_done <= 1'b0;
         @(posedge clk);
         #1 check(standby, 1'b1);
         n = 0;
         while (standby === 1'b1 && n < 600)
         begin
            @(posedge clk);
            filt_word_stb <= 1'b1;
            @(posedge clk);
            filt_word_stb <= 1'b0;
            n++;
            @(posedge clk);
            #1;
         end
         check(n, (d + 1) * 2);
         @(posedge clk);
         periodic_en <= 1'b0;
      end
      $display("test standby done");
      conclude;
   end

   // cut a hang short well beyond the expected run
   initial
   begin
      #3000000;
      fail_count++;
      conclude;
   end
endmodule
